/* File: src/tcd_map.vh */
`ifndef TCD_MAP_VH
`define TCD_MAP_VH

// Register indices; byte address is four times the index
`define TCD_IDX_THERM_EVT 6'h0f
`define TCD_IDX_DET_EVT 6'h10
`define TCD_IDX_THERM_ENA 6'h18
`define TCD_IDX_DET_ENA 6'h19
`define TCD_IDX_THERM_STAT 6'h1a
`define TCD_IDX_DET_STAT 6'h1b
`define TCD_IDX_SUMMARY 6'h1c

// Thermal event register fields
`define TCD_TH_CUR_BIT 6
`define TCD_TH_VLT_BIT 5
`define TCD_TH_ZONE_BIT 4
`define TCD_TH_USED 8'h70

// Detection event register fields
`define TCD_DT_BUS_BIT 7
`define TCD_DT_RUNF_BIT 4
`define TCD_DT_RUNR_BIT 3
`define TCD_DT_PRT_BIT 2
`define TCD_DT_DCD_BIT 1
`define TCD_DT_CT_BIT 0
`define TCD_DT_USED 8'h9f

// Reset values
`define TCD_EVT_RESET 8'h00
`define TCD_ENA_RESET 8'hff

// Status readback field positions
`define TCD_TS_ZONE_LSB 0
`define TCD_TS_VLT_BIT 3
`define TCD_TS_CUR_BIT 4
`define TCD_DS_BUS_BIT 0
`define TCD_DS_RUN_BIT 1
`define TCD_DS_DCD_BIT 2
`define TCD_DS_CT_LSB 8
`define TCD_DS_PRT_LSB 16

// Widths of status fields
`define TCD_ZONE_W 3
`define TCD_CT_W 2
`define TCD_PRT_W 3

`endif

/* File: src/tcd_change_det.v */
`timescale 1ns/1ps
// Change and edge detector for a group of status bits
module tcd_change_det #(
  parameter WIDTH = 1
) (
  input wire ref_clk_i, // System clock
  input wire nrst_i, // Synchronous reset, active low
  input wire [WIDTH-1:0] cur_i, // Status value to watch
  output wire change_o, // Any bit differs from last cycle
  output wire rise_o, // Bit 0 went zero to one
  output wire fall_o // Bit 0 went one to zero
);

  reg [WIDTH-1:0] prev;
  reg armed;

  // Previous value; not armed until one value has been seen
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      prev <= {WIDTH{1'b0}};
      armed <= 1'b0;
    end else begin
      prev <= cur_i;
      armed <= 1'b1;
    end
  end

  // Compare against previous value
  assign change_o = armed & (|(cur_i ^ prev));
  assign rise_o = armed & cur_i[0] & ~prev[0];
  assign fall_o = armed & ~cur_i[0] & prev[0];

endmodule // tcd_change_det

/* File: src/tcd_event_flags.v */
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "tcd_map.vh"
module tcd_event_flags #(
  parameter ZONE_W = `TCD_ZONE_W,
  parameter CT_W = `TCD_CT_W,
  parameter PRT_W = `TCD_PRT_W
) (
  input wire ref_clk_i, // System clock, 125 MHz
  input wire nrst_i, // Synchronous reset, active low
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire thermal_current_reg_status_i, // Thermal current regulation active
  input wire thermal_voltage_reg_status_i, // Thermal voltage regulation active
  input wire [ZONE_W-1:0] thermal_zone_status_i, // Thermistor zone
  input wire bus_power_present_i, // Bus power detected
  input wire detection_running_i, // Charger detection in progress
  input wire [PRT_W-1:0] proprietary_type_result_i, // Proprietary type result
  input wire contact_timeout_status_i, // Contact detect timed out
  input wire [CT_W-1:0] charger_type_result_i, // Charger type result
  output reg thermal_pending_o, // Some thermal flag is set
  output reg detect_pending_o // Some detection flag is set
);

  // Register index decode
  function idx_hit;
    input [7:0] adr;
    input [5:0] idx;
    begin
      idx_hit = (adr[7:2] == idx);
    end
  endfunction

  // Byte-lane merge for 8-bit writable registers
  function [7:0] lane0_merge;
    input [7:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    begin
      lane0_merge = sel[0] ? wdat[7:0] : old;
    end
  endfunction

  reg [7:0] thermal_event_flags;
  reg [7:0] charger_detect_event_flags;
  reg [7:0] thermal_event_enable;
  reg [7:0] detect_event_enable;
  reg [7:0] next_thermal_flags;
  reg [7:0] next_detect_flags;
  reg [7:0] thermal_hits;
  reg [7:0] detect_hits;
  reg [31:0] next_rdata;
  reg rd_therm;
  reg rd_det;
  wire bus_take;
  wire th_cur_chg;
  wire th_vlt_chg;
  wire th_zone_chg;
  wire bus_chg;
  wire run_rise;
  wire run_fall;
  wire prt_chg;
  wire dcd_chg;
  wire ct_chg;
  reg [31:0] therm_stat_word;
  wire [31:0] det_stat_word;

  // Status change detectors
  tcd_change_det #(.WIDTH(1)) u_th_cur (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(thermal_current_reg_status_i),
    .change_o(th_cur_chg),
    .rise_o(),
    .fall_o()
  );

  tcd_change_det #(.WIDTH(1)) u_th_vlt (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(thermal_voltage_reg_status_i),
    .change_o(th_vlt_chg),
    .rise_o(),
    .fall_o()
  );

  tcd_change_det #(.WIDTH(ZONE_W)) u_th_zone (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(thermal_zone_status_i),
    .change_o(th_zone_chg),
    .rise_o(),
    .fall_o()
  );

  tcd_change_det #(.WIDTH(1)) u_bus (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(bus_power_present_i),
    .change_o(bus_chg),
    .rise_o(),
    .fall_o()
  );

  tcd_change_det #(.WIDTH(1)) u_run (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(detection_running_i),
    .change_o(),
    .rise_o(run_rise),
    .fall_o(run_fall)
  );

  tcd_change_det #(.WIDTH(PRT_W)) u_prt (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(proprietary_type_result_i),
    .change_o(prt_chg),
    .rise_o(),
    .fall_o()
  );

  tcd_change_det #(.WIDTH(1)) u_dcd (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(contact_timeout_status_i),
    .change_o(dcd_chg),
    .rise_o(),
    .fall_o()
  );

  tcd_change_det #(.WIDTH(CT_W)) u_ct (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cur_i(charger_type_result_i),
    .change_o(ct_chg),
    .rise_o(),
    .fall_o()
  );

  // Event vectors in register bit order, gated by enables
  always @* begin
    thermal_hits = 8'h00;
    thermal_hits[`TCD_TH_CUR_BIT] = th_cur_chg;
    thermal_hits[`TCD_TH_VLT_BIT] = th_vlt_chg;
    thermal_hits[`TCD_TH_ZONE_BIT] = th_zone_chg;
    thermal_hits = thermal_hits & thermal_event_enable & `TCD_TH_USED;
    detect_hits = 8'h00;
    detect_hits[`TCD_DT_BUS_BIT] = bus_chg;
    detect_hits[`TCD_DT_RUNF_BIT] = run_fall;
    detect_hits[`TCD_DT_RUNR_BIT] = run_rise;
    detect_hits[`TCD_DT_PRT_BIT] = prt_chg;
    detect_hits[`TCD_DT_DCD_BIT] = dcd_chg;
    detect_hits[`TCD_DT_CT_BIT] = ct_chg;
    detect_hits = detect_hits & detect_event_enable & `TCD_DT_USED;
  end

  // A request is taken on the first cycle it is seen
  assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Reads of the event registers
  always @* begin
    rd_therm = bus_take & ~wb_we_i & idx_hit(wb_adr_i, `TCD_IDX_THERM_EVT);
    rd_det = bus_take & ~wb_we_i & idx_hit(wb_adr_i, `TCD_IDX_DET_EVT);
  end

  // Sticky flags: read clears, a new event in the same cycle survives
  always @* begin
    next_thermal_flags = rd_therm ? 8'h00 : thermal_event_flags;
    next_thermal_flags = next_thermal_flags | thermal_hits;
    next_detect_flags = rd_det ? 8'h00 : charger_detect_event_flags;
    next_detect_flags = next_detect_flags | detect_hits;
  end

  // Flag storage
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      thermal_event_flags <= `TCD_EVT_RESET;
      charger_detect_event_flags <= `TCD_EVT_RESET;
    end else begin
      thermal_event_flags <= next_thermal_flags;
      charger_detect_event_flags <= next_detect_flags;
    end
  end

  // Live status words; bit placement avoids a zero-width filler
  always @* begin
    therm_stat_word = 32'h0000_0000;
    therm_stat_word[`TCD_TS_ZONE_LSB +: ZONE_W] = thermal_zone_status_i;
    therm_stat_word[`TCD_TS_VLT_BIT] = thermal_voltage_reg_status_i;
    therm_stat_word[`TCD_TS_CUR_BIT] = thermal_current_reg_status_i;
  end
  assign det_stat_word = {
    {(32 - `TCD_DS_PRT_LSB - PRT_W){1'b0}},
    proprietary_type_result_i,
    {(`TCD_DS_PRT_LSB - `TCD_DS_CT_LSB - CT_W){1'b0}},
    charger_type_result_i,
    {(`TCD_DS_CT_LSB - `TCD_DS_DCD_BIT - 1){1'b0}},
    contact_timeout_status_i,
    detection_running_i,
    bus_power_present_i
  };

  // Read data mux; unmapped addresses read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (idx_hit(wb_adr_i, `TCD_IDX_THERM_EVT)) begin
      next_rdata[7:0] = thermal_event_flags;
    end else if (idx_hit(wb_adr_i, `TCD_IDX_DET_EVT)) begin
      next_rdata[7:0] = charger_detect_event_flags;
    end else if (idx_hit(wb_adr_i, `TCD_IDX_THERM_ENA)) begin
      next_rdata[7:0] = thermal_event_enable;
    end else if (idx_hit(wb_adr_i, `TCD_IDX_DET_ENA)) begin
      next_rdata[7:0] = detect_event_enable;
    end else if (idx_hit(wb_adr_i, `TCD_IDX_THERM_STAT)) begin
      next_rdata = therm_stat_word;
    end else if (idx_hit(wb_adr_i, `TCD_IDX_DET_STAT)) begin
      next_rdata = det_stat_word;
    end else if (idx_hit(wb_adr_i, `TCD_IDX_SUMMARY)) begin
      next_rdata[0] = |thermal_event_flags;
      next_rdata[1] = |charger_detect_event_flags;
    end
  end

  // Wishbone answer: one ack per request, read data frozen with it
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_take;
      if (bus_take && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // Enable registers written through byte lane 0
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      thermal_event_enable <= `TCD_ENA_RESET;
      detect_event_enable <= `TCD_ENA_RESET;
    end else if (bus_take && wb_we_i) begin
      if (idx_hit(wb_adr_i, `TCD_IDX_THERM_ENA)) begin
        thermal_event_enable <= lane0_merge(thermal_event_enable, wb_dat_i, wb_sel_i);
      end
      if (idx_hit(wb_adr_i, `TCD_IDX_DET_ENA)) begin
        detect_event_enable <= lane0_merge(detect_event_enable, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Pending indicators follow the flags
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      thermal_pending_o <= 1'b0;
      detect_pending_o <= 1'b0;
    end else begin
      thermal_pending_o <= |next_thermal_flags;
      detect_pending_o <= |next_detect_flags;
    end
  end

endmodule // tcd_event_flags

/* File: verif/tcd_event_flags_assertions.sv */
`timescale 1ns/1ps
// Port-level checks of event latching and bus answer
module tcd_event_flags_checker #(
  parameter ZONE_W = 3,
  parameter CT_W = 2,
  parameter PRT_W = 3
) (
  input wire ref_clk_i, // Clock
  input wire nrst_i, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire wb_ack_o, // Ack
  input wire thermal_current_reg_status_i, // Status
  input wire thermal_voltage_reg_status_i, // Status
  input wire [ZONE_W-1:0] thermal_zone_status_i, // Status
  input wire bus_power_present_i, // Status
  input wire detection_running_i, // Status
  input wire [PRT_W-1:0] proprietary_type_result_i, // Status
  input wire contact_timeout_status_i, // Status
  input wire [CT_W-1:0] charger_type_result_i, // Status
  input wire thermal_pending_o, // Thermal flag
  input wire detect_pending_o // Detect flag
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Taken request and taken thermal and detect reads
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire th_rd = tk && !wb_we_i && wb_adr_i[7:2] == 6'h0f;
  wire dt_rd = tk && !wb_we_i && wb_adr_i[7:2] == 6'h10;
  property p_ack;
    tk |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_cur;
    $past(nrst_i) && $changed(thermal_current_reg_status_i) |=> thermal_pending_o;
  endproperty
  a_cur: assert property (p_cur) else $error("current event lost");
  property p_hold;
    thermal_pending_o && !th_rd |=> thermal_pending_o;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost unread");
  property p_dhold;
    detect_pending_o && !dt_rd |=> detect_pending_o;
  endproperty
  a_dhold: assert property (p_dhold) else $error("detect flag lost unread");
  property p_clr;
    th_rd && $stable(thermal_voltage_reg_status_i) && $stable(thermal_current_reg_status_i)
      && $stable(thermal_zone_status_i) |=> !thermal_pending_o;
  endproperty
  a_clr: assert property (p_clr) else $error("thermal flags not cleared by read");
  property p_dclr;
    dt_rd && $stable(bus_power_present_i) && $stable(detection_running_i)
      && $stable(proprietary_type_result_i) && $stable(contact_timeout_status_i)
      && $stable(charger_type_result_i) |=> !detect_pending_o;
  endproperty
  a_dclr: assert property (p_dclr) else $error("detect flags not cleared by read");
  property p_vlt;
    $past(nrst_i) && $changed(thermal_voltage_reg_status_i) |=> thermal_pending_o;
  endproperty
  a_vlt: assert property (p_vlt) else $error("voltage event lost");
  property p_quiet;
    $past(nrst_i) && !thermal_pending_o && $stable(thermal_voltage_reg_status_i)
      && $stable(thermal_current_reg_status_i) && $stable(thermal_zone_status_i)
      |=> !thermal_pending_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag without change");
  property p_zone;
    $past(nrst_i) && $changed(thermal_zone_status_i) |=> thermal_pending_o;
  endproperty
  a_zone: assert property (p_zone) else $error("zone event lost");
  property p_bus;
    $past(nrst_i) && $changed(bus_power_present_i) |=> detect_pending_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus event lost");
  property p_fall;
    $past(nrst_i) && $fell(detection_running_i) |=> detect_pending_o;
  endproperty
  a_fall: assert property (p_fall) else $error("fall event lost");
  property p_rise;
    $past(nrst_i) && $rose(detection_running_i) |=> detect_pending_o;
  endproperty
  a_rise: assert property (p_rise) else $error("rise event lost");
  property p_prt;
    $past(nrst_i) && $changed(proprietary_type_result_i) |=> detect_pending_o;
  endproperty
  a_prt: assert property (p_prt) else $error("type event lost");
  property p_dcd;
    $past(nrst_i) && $changed(contact_timeout_status_i) |=> detect_pending_o;
  endproperty
  a_dcd: assert property (p_dcd) else $error("timeout event lost");
  property p_ct;
    $past(nrst_i) && $changed(charger_type_result_i) |=> detect_pending_o;
  endproperty
  a_ct: assert property (p_ct) else $error("result event lost");
endmodule // tcd_event_flags_checker

bind tcd_event_flags tcd_event_flags_checker #(
  .ZONE_W(ZONE_W), .CT_W(CT_W), .PRT_W(PRT_W)
) u_tcd_event_flags_checker (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .thermal_current_reg_status_i(thermal_current_reg_status_i),
  .thermal_voltage_reg_status_i(thermal_voltage_reg_status_i),
  .thermal_zone_status_i(thermal_zone_status_i), .bus_power_present_i(bus_power_present_i),
  .detection_running_i(detection_running_i),
  .proprietary_type_result_i(proprietary_type_result_i),
  .contact_timeout_status_i(contact_timeout_status_i),
  .charger_type_result_i(charger_type_result_i),
  .thermal_pending_o(thermal_pending_o), .detect_pending_o(detect_pending_o)
);

/* File: verif/tb_thermal_and_charger_detect_irq_flags.sv */
`timescale 1ns/1ps
// Random status traffic with read-clear checks
module tb_thermal_and_charger_detect_irq_flags;
  reg ref_clk_i = 1'h0;
  reg nrst_i = 1'h0;
  reg cyc = 1'h0;
  reg we = 1'h0;
  reg [7:0] adr = 8'h0;
  reg [31:0] dat = 32'h0;
  reg [12:0] s = 13'h0;
  reg [12:0] n;
  reg [12:0] c;
  reg [15:0] r = 16'h3d94;
  reg [7:0] eth = 8'h0;
  reg [7:0] edt = 8'h0;
  reg [31:0] q [$];
  wire [31:0] rdat;
  wire ack;
  wire tp;
  wire dp;
  integer mismatches = 0;
  integer tests_run = 0;
  integer cnt = 0;
  integer i;
  always #4 ref_clk_i = ~ref_clk_i;
  tcd_event_flags u_tcd_event_flags (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .thermal_current_reg_status_i(s[12]), .thermal_voltage_reg_status_i(s[11]),
    .thermal_zone_status_i(s[10:8]), .bus_power_present_i(s[7]), .detection_running_i(s[6]),
    .proprietary_type_result_i(s[5:3]), .contact_timeout_status_i(s[2]),
    .charger_type_result_i(s[1:0]), .thermal_pending_o(tp), .detect_pending_o(dp)
  );
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One classic cycle, held until ack
  task bus(input [7:0] a, input w, input [31:0] d);
    @(posedge ref_clk_i);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge ref_clk_i);
    while (ack !== 1'h1) @(posedge ref_clk_i);
    cyc <= 1'h0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    q.push_back(e);
    bus(a, 1'h0, 32'h0);
  endtask
  // Compare each read answer with the oldest note
  always @(posedge ref_clk_i) begin
    if (ack === 1'h1 && we === 1'h0) check(rdat, q.pop_front());
  end
  // Cycle ceiling
  always @(posedge ref_clk_i) begin
    cnt <= cnt + 1;
    if (cnt == 20000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    rd(8'h60, 32'hff);
    rd(8'h64, 32'hff);
    bus(8'h64, 1'h1, 32'hff);
    rd(8'h64, 32'hff);
    bus(8'h3c, 1'h1, 32'hff);
    rd(8'h3c, 32'h0);
    rd(8'hfc, 32'h0);
    $display("test register access done");
    for (i = 0; i < 300; i = i + 1) begin
      // Wait first so that s already holds the last applied value
      @(posedge ref_clk_i);
      r = lfsr(r);
      n = r[15] ? s : r[12:0];
      c = n ^ s;
      eth = eth | {1'h0, c[12], c[11], |c[10:8], 4'h0};
      edt = edt | {c[7], 2'h0, s[6] & ~n[6], ~s[6] & n[6], |c[5:3], c[2], |c[1:0]};
      s <= n;
      if (r[14]) begin
        rd(8'h3c, {24'h0, eth});
        rd(8'h40, {24'h0, edt});
        eth = 8'h0;
        edt = 8'h0;
      end
    end
    rd(8'h3c, {24'h0, eth});
    rd(8'h40, {24'h0, edt});
    rd(8'h40, 32'h0);
    rd(8'h68, {27'h0, s[12], s[11], s[10:8]});
    rd(8'h6c, {13'h0, s[5:3], 6'h0, s[1:0], 5'h0, s[2], s[6], s[7]});
    rd(8'h70, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    $display("test random events done");
    give_verdict;
  end
endmodule // tb_thermal_and_charger_detect_irq_flags
